/* src/swg_write_guard.sv */
// Purpose: write-enable latch and per-sector protection of a serial flash
// Assumes: program/erase logic reports frame ends and asks about addresses
// Notes:   commands take effect one clock after select release is seen
//
// Summary of operation
// - latch-set opcode, whole bytes, select released: latch becomes 1.
// - protect, unprotect, program, erase refused while the latch is 0.
// - latch commands with a partial byte after the opcode abort, latch kept; an incomplete opcode is ignored.
// - latch-clear opcode, whole bytes, select released: latch becomes 0.
// - latch-clear also ends sequential program mode.
// - no address with latch commands; bytes after the opcode are ignored.
// - one protection bit per sector, all set to 1 at reset.
// - bit 0 allows program and erase, bit 1 rejects them.
// - protect plus three address bytes sets the sector bit at release.
// - unprotect plus three address bytes clears the sector bit at release.
// - successful protect or unprotect clears the latch.
// - short address or partial byte aborts, bit kept, latch cleared.
// - lock bit set: protect ignored, latch cleared, back to idle.
// - sector chosen from address bits SECTOR_LSB upward (bits 19:16 by default).
// - lock bit set: unprotect ignored, latch cleared, back to idle.
// - program to protected sector not executed; latch cleared at its end.
`timescale 1ns/1ps
module swg_write_guard #(
   parameter int NUM_SECTORS = swg_pkg::NUM_SECTORS_DEF,
   parameter int SECTOR_LSB  = swg_pkg::SECTOR_LSB_DEF
) (
   input  wire logic                      clk_in,
   input  wire logic                      rst_in,
   input  wire logic                      sck_in,
   input  wire logic                      cs_n_in,
   input  wire logic                      mosi_in,
   input  wire logic                      protection_lock_bit_in,
   input  wire logic [swg_pkg::ADDR_W-1:0] op_addr_in,
   input  wire logic                      op_end_in,
   output logic                           write_enable_latch_out,
   output logic [NUM_SECTORS-1:0]         sector_prot_out,
   output logic                           op_allowed_out,
   output logic                           seq_exit_out,
   output logic                           cmd_done_out,
   output logic                           cmd_abort_out
);

   localparam int SW = $clog2(NUM_SECTORS);

   // sector index is a plain bit field, so the count must be a power of two
   if (NUM_SECTORS < 2 || (1 << SW) != NUM_SECTORS) begin : g_chk_count
      $error("swg_write_guard: sector count must be a power of two");
   end

   if (SECTOR_LSB < 0 || SECTOR_LSB + SW > swg_pkg::ADDR_W) begin : g_chk_map
      $error("swg_write_guard: sector map does not fit the address");
   end

   // the receiver stores the address as three whole bytes
   if (swg_pkg::ADDR_W != 3 * swg_pkg::BYTE_W) begin : g_chk_addr
      $error("swg_write_guard: address must be three bytes");
   end

   typedef enum logic [2:0] {
      SWG_IDLE   = 3'b001,
      SWG_ACTIVE = 3'b010,
      SWG_EVAL   = 3'b100
   } swg_state_t;

   swg_state_t             state_q;
   swg_state_t             state_d;
   swg_pkg::swg_frame_t    frame_link;
   swg_pkg::swg_frame_t    snap_q;
   logic                   frame_tgl;
   logic                   link_rst_q;
   logic [1:0]             sync_bits;
   logic                   cs_n_s;
   logic                   tgl_s;
   logic                   seen_q;
   logic                   fresh_q;
   logic                   latch_q;
   logic                   latch_d;
   logic [NUM_SECTORS-1:0] prot_q;
   logic [NUM_SECTORS-1:0] prot_d;

   // link side reset comes from a flop so it is glitch free
   always_ff @(posedge clk_in) begin
      link_rst_q <= rst_in;
   end

   swg_link_rx u_link (
      .sck_in        (sck_in),
      .cs_n_in       (cs_n_in),
      .link_rst_in   (link_rst_q),
      .mosi_in       (mosi_in),
      .frame_out     (frame_link),
      .frame_tgl_out (frame_tgl)
   );

   // select and frame toggle into the core clock
   swg_sync #(
      .WIDTH     (2),
      .RESET_VAL ({6'h00, swg_pkg::CS_N_RESET, swg_pkg::TOGGLE_RESET})
   ) u_sync (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .d_in   ({cs_n_in, frame_tgl}),
      .q_out  (sync_bits)
   );

   assign cs_n_s = sync_bits[1];
   assign tgl_s  = sync_bits[0];

   // frame decode on the snapshot taken at select release
   wire            release_seen = (state_q == SWG_ACTIVE) && cs_n_s;
   wire            in_eval      = (state_q == SWG_EVAL);
   wire            on_boundary  = fresh_q && (snap_q.bits == swg_pkg::BIT_BOUNDARY);
   wire            opcode_whole = on_boundary && (snap_q.nbytes >= swg_pkg::CNT_OPCODE_ONLY);
   wire            addr_whole   = on_boundary && (snap_q.nbytes == swg_pkg::CNT_WITH_ADDR);
   wire            has_opcode   = fresh_q && (snap_q.nbytes >= swg_pkg::CNT_OPCODE_ONLY);
   wire            is_set       = has_opcode && (snap_q.opcode == swg_pkg::OP_LATCH_SET);
   wire            is_clear     = has_opcode && (snap_q.opcode == swg_pkg::OP_LATCH_CLEAR);
   wire            is_prot      = has_opcode && (snap_q.opcode == swg_pkg::OP_SECTOR_PROT);
   wire            is_unprot    = has_opcode && (snap_q.opcode == swg_pkg::OP_SECTOR_UNPROT);
   wire            is_sector    = is_prot || is_unprot;
   wire            sec_locked   = is_sector && protection_lock_bit_in;
   wire            sec_go       = is_sector && !protection_lock_bit_in && latch_q && addr_whole;
   wire            sec_abort    = is_sector && !protection_lock_bit_in && latch_q && !addr_whole;
   wire [SW-1:0]   cmd_sector   = snap_q.addr[SECTOR_LSB +: SW];
   wire [SW-1:0]   op_sector    = op_addr_in[SECTOR_LSB +: SW];
   wire            latch_ok     = (is_set || is_clear) && opcode_whole;
   wire            cmd_ok       = latch_ok || sec_go;
   wire            cmd_bad      = ((is_set || is_clear) && !opcode_whole)
                                  || sec_abort || sec_locked
                                  || (is_sector && !latch_q);

   always_comb begin
      state_d = state_q;
      case (state_q)
         SWG_IDLE:   if (!cs_n_s) state_d = SWG_ACTIVE;
         SWG_ACTIVE: if (cs_n_s) state_d = SWG_EVAL;
         SWG_EVAL:   state_d = SWG_IDLE;
         default:    state_d = SWG_IDLE;
      endcase
   end

   // one named cause for every latch or bit change
   wire            latch_set_go   = in_eval && is_set && opcode_whole;
   wire            latch_clear_go = in_eval && is_clear && opcode_whole;
   wire            latch_drop_sec = in_eval && (sec_locked || sec_go || sec_abort);
   wire            prot_write_go  = in_eval && sec_go;
   wire            op_sector_prot = prot_d[op_sector];

   always_comb begin
      latch_d = latch_q;
      // any program or erase frame end drops the latch, refused or not
      if (op_end_in) begin
         latch_d = 1'b0;
      end
      // a command result in the same cycle wins over the frame end
      if (latch_set_go) begin
         latch_d = 1'b1;
      end
      if (latch_clear_go) begin
         latch_d = 1'b0;
      end
      if (latch_drop_sec) begin
         latch_d = 1'b0;
      end
   end

   always_comb begin
      prot_d = prot_q;
      if (prot_write_go) begin
         prot_d[cmd_sector] = is_prot;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_q <= SWG_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // link fields are static once the select is high
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         snap_q <= '0;
      end else if (release_seen) begin
         snap_q <= frame_link;
      end
   end

   // a frame counts only if its toggle moved, so a select with no clock does nothing
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         seen_q  <= swg_pkg::TOGGLE_RESET;
         fresh_q <= 1'b0;
      end else if (release_seen) begin
         seen_q  <= tgl_s;
         fresh_q <= (tgl_s != seen_q);
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         latch_q <= swg_pkg::LATCH_RESET;
      end else begin
         latch_q <= latch_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         prot_q <= {NUM_SECTORS{swg_pkg::PROT_RESET}};
      end else begin
         prot_q <= prot_d;
      end
   end

   // outputs show the values being written this cycle, one flop each
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         write_enable_latch_out <= swg_pkg::LATCH_RESET;
      end else begin
         write_enable_latch_out <= latch_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sector_prot_out <= {NUM_SECTORS{swg_pkg::PROT_RESET}};
      end else begin
         sector_prot_out <= prot_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         op_allowed_out <= 1'b0;
      end else begin
         op_allowed_out <= latch_d && !op_sector_prot;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         seq_exit_out <= 1'b0;
      end else begin
         seq_exit_out <= latch_clear_go;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cmd_done_out <= 1'b0;
      end else begin
         cmd_done_out <= in_eval && cmd_ok;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cmd_abort_out <= 1'b0;
      end else begin
         cmd_abort_out <= in_eval && cmd_bad;
      end
   end

endmodule : swg_write_guard

/* src/swg_pkg.sv */
// Purpose: shared constants and types of the flash write guard
// Assumes: serial link in mode 0 or 3, data sampled on the rising link clock
// Notes:   opcodes, field layouts and reset values live here only
package swg_pkg;

   // command opcodes
   localparam logic [7:0] OP_LATCH_SET     = 8'h06;
   localparam logic [7:0] OP_LATCH_CLEAR   = 8'h04;
   localparam logic [7:0] OP_SECTOR_PROT   = 8'h36;
   localparam logic [7:0] OP_SECTOR_UNPROT = 8'h39;

   // frame layout
   localparam int         ADDR_W          = 24;
   localparam int         BYTE_W          = 8;
   localparam logic [2:0] CNT_OPCODE_ONLY = 3'h1;
   localparam logic [2:0] CNT_WITH_ADDR   = 3'h4;
   localparam logic [2:0] BIT_LAST        = 3'h7;
   localparam logic [2:0] BIT_BOUNDARY    = 3'h0;

   // sector map defaults
   localparam int NUM_SECTORS_DEF = 16;
   localparam int SECTOR_LSB_DEF  = 16;

   // reset values
   localparam logic LATCH_RESET  = 1'b0;
   localparam logic PROT_RESET   = 1'b1;
   localparam logic CS_N_RESET   = 1'b1;
   localparam logic TOGGLE_RESET = 1'b0;

   // what the link side captured in the last frame; static once the frame ends
   typedef struct packed {
      logic [7:0]        opcode;
      logic [ADDR_W-1:0] addr;
      logic [2:0]        nbytes;
      logic [2:0]        bits;
   } swg_frame_t;

endpackage : swg_pkg

/* src/swg_sync.sv */
// Purpose: two-flop synchroniser for levels entering the core clock
// Assumes: inputs are levels or toggles that hold for several clocks
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module swg_sync #(
   parameter int         WIDTH     = 1,
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);

   logic [WIDTH-1:0] meta_q;

   if (WIDTH < 1 || WIDTH > 8) begin : g_chk
      $error("swg_sync: WIDTH must be 1 to 8");
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meta_q <= RESET_VAL[WIDTH-1:0];
         q_out  <= RESET_VAL[WIDTH-1:0];
      end else begin
         meta_q <= d_in;
         q_out  <= meta_q;
      end
   end

endmodule : swg_sync

/* src/swg_link_rx.sv */
// Purpose: link-clock receiver, captures opcode, address and bit counts
// Assumes: link clock stops outside frames; select high between frames
// Notes:   captured fields are kept between frames until the first edge of a new frame
`timescale 1ns/1ps
module swg_link_rx (
   input  wire logic              sck_in,
   input  wire logic              cs_n_in,
   input  wire logic              link_rst_in,
   input  wire logic              mosi_in,
   output swg_pkg::swg_frame_t    frame_out,
   output logic                   frame_tgl_out
);

   logic       first_q;
   logic [6:0] shift_q;
   logic [2:0] cur_bit;
   logic [2:0] cur_cnt;
   logic [7:0] rx_byte;
   logic       byte_done;

   // armed while select is high, so the next edge starts a fresh frame
   always_ff @(posedge sck_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         first_q <= 1'b1;
      end else begin
         first_q <= 1'b0;
      end
   end

   assign cur_bit   = first_q ? swg_pkg::BIT_BOUNDARY : frame_out.bits;
   assign cur_cnt   = first_q ? 3'h0 : frame_out.nbytes;
   assign rx_byte   = {shift_q, mosi_in};
   assign byte_done = (cur_bit == swg_pkg::BIT_LAST);

   always_ff @(posedge sck_in or posedge link_rst_in) begin
      if (link_rst_in) begin
         shift_q       <= 7'h00;
         frame_out     <= '0;
         frame_tgl_out <= swg_pkg::TOGGLE_RESET;
      end else begin
         shift_q        <= rx_byte[6:0];
         frame_out.bits <= cur_bit + 3'h1;
         if (first_q) begin
            frame_tgl_out <= ~frame_tgl_out;
         end
         if (first_q) begin
            frame_out.nbytes <= 3'h0;
         end
         if (byte_done && cur_cnt < swg_pkg::CNT_WITH_ADDR) begin
            // bytes past the address are not stored
            frame_out.nbytes <= cur_cnt + 3'h1;
            case (cur_cnt)
               3'h0:    frame_out.opcode      <= rx_byte;
               3'h1:    frame_out.addr[23:16] <= rx_byte;
               3'h2:    frame_out.addr[15:8]  <= rx_byte;
               default: frame_out.addr[7:0]   <= rx_byte;
            endcase
         end
      end
   end

endmodule : swg_link_rx

/* sim/swg_write_guard_properties.sv */
// Purpose: timing relations of the write guard outputs
// Assumes: lock bit and op address held steady around frames
// Notes:   bound to every swg_write_guard
`timescale 1ns/1ps
module swg_write_guard_properties #(
   parameter int NUM_SECTORS = 16,
   parameter int SECTOR_LSB  = 16
) (
   input wire logic                       clk_in,
   input wire logic                       rst_in,
   input wire logic                       protection_lock_bit_in,
   input wire logic [swg_pkg::ADDR_W-1:0] op_addr_in,
   input wire logic                       op_end_in,
   input wire logic                       write_enable_latch_out,
   input wire logic [NUM_SECTORS-1:0]     sector_prot_out,
   input wire logic                       op_allowed_out,
   input wire logic                       seq_exit_out,
   input wire logic                       cmd_done_out,
   input wire logic                       cmd_abort_out
);
   localparam int SW = $clog2(NUM_SECTORS);
   logic [swg_pkg::ADDR_W-1:0] addr_q;
   logic                       rst_q;
   always_ff @(posedge clk_in) addr_q <= op_addr_in;
   // reset drops at a clock edge, so checks stay off for that edge as well
   always_ff @(posedge clk_in) rst_q <= rst_in;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in || rst_q);
   prot_reset_a: assert property ($fell(rst_in) |->
      &sector_prot_out && !write_enable_latch_out) else $error("reset values wrong");
   prot_cause_a: assert property (!$stable(sector_prot_out) |->
      cmd_done_out && !write_enable_latch_out) else $error("bit change without done");
   prot_guard_a: assert property (!$stable(sector_prot_out) |->
      $past(write_enable_latch_out) && !$past(protection_lock_bit_in))
      else $error("bit changed while refused");
   prot_single_a: assert property ($onehot0(sector_prot_out ^ $past(sector_prot_out)))
      else $error("several bits changed");
   allowed_map_a: assert property (op_allowed_out ==
      (write_enable_latch_out && !sector_prot_out[addr_q[SECTOR_LSB +: SW]]))
      else $error("allowed flag wrong");
   seq_exit_a: assert property (seq_exit_out |->
      cmd_done_out && !write_enable_latch_out) else $error("exit pulse wrong");
   latch_rise_a: assert property ($rose(write_enable_latch_out) |->
      cmd_done_out && !cmd_abort_out) else $error("latch set without done");
   op_end_a: assert property (op_end_in |=>
      !write_enable_latch_out || cmd_done_out) else $error("latch kept after op end");
   abort_keep_a: assert property (cmd_abort_out |-> $stable(sector_prot_out))
      else $error("abort changed bits");
   abort_latch_a: assert property (cmd_abort_out |-> !$rose(write_enable_latch_out))
      else $error("abort set latch");
endmodule : swg_write_guard_properties

bind swg_write_guard swg_write_guard_properties #(
   .NUM_SECTORS(NUM_SECTORS), .SECTOR_LSB(SECTOR_LSB)) props (
   .clk_in(clk_in), .rst_in(rst_in), .protection_lock_bit_in(protection_lock_bit_in),
   .op_addr_in(op_addr_in), .op_end_in(op_end_in),
   .write_enable_latch_out(write_enable_latch_out), .sector_prot_out(sector_prot_out),
   .op_allowed_out(op_allowed_out), .seq_exit_out(seq_exit_out),
   .cmd_done_out(cmd_done_out), .cmd_abort_out(cmd_abort_out));

/* sim/swg_host.sv */
// Purpose: host side of the serial link, sends whole or cut frames
// Assumes: mode 0, link clock idle low and still between frames
// Notes:   data line shows the inverse of its last bit while deselected
`timescale 1ns/1ps
module swg_host (
   output logic sck_out,
   output logic cs_n_out,
   output logic mosi_out
);
   initial begin
      sck_out  = 1'b0;
      cs_n_out = 1'b1;
      mosi_out = 1'b0;
   end
   // n bits of d, msb first, 80 ns link period
   task automatic send(input logic [39:0] d, input int n);
      #13 cs_n_out = 1'b0;
      for (int i = 0; i < n; i++) begin
         mosi_out = d[39-i];
         #40 sck_out = 1'b1;
         #40 sck_out = 1'b0;
      end
      #40 cs_n_out = 1'b1;
      mosi_out = ~mosi_out;
   endtask : send
endmodule : swg_host

/* sim/testbench.sv */
// Purpose: self-checking bench of the flash write guard
// Assumes: host model drives the link, bench drives the core side
// Notes:   each frame is followed by a fixed window for its pulses
`timescale 1ns/1ps
module testbench;
   logic                       clk_in = 1'b0;
   logic                       rst_in = 1'b1;
   logic                       lock   = 1'b0;
   logic [swg_pkg::ADDR_W-1:0] addr   = 24'h0;
   logic                       op_end = 1'b0;
   logic                       sck, cs_n, mosi, latch, allowed, seq, done, abrt;
   logic [15:0]                prot, ep;
   int                         errors = 0, comparisons = 0, cyc = 0;
   always #20 clk_in = ~clk_in;
   swg_host host (.sck_out(sck), .cs_n_out(cs_n), .mosi_out(mosi));
   swg_write_guard dut (.clk_in(clk_in), .rst_in(rst_in), .sck_in(sck), .cs_n_in(cs_n),
      .mosi_in(mosi), .protection_lock_bit_in(lock), .op_addr_in(addr), .op_end_in(op_end),
      .write_enable_latch_out(latch), .sector_prot_out(prot), .op_allowed_out(allowed),
      .seq_exit_out(seq), .cmd_done_out(done), .cmd_abort_out(abrt));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   // frame, then pulses {done,abort,exit}, latch and bits
   task automatic cmd(input logic [39:0] d, input int n, input logic w,
                      input logic [2:0] r);
      logic [2:0] seen;
      seen = 3'h0;
      host.send(d, n);
      repeat (8) begin
         @(posedge clk_in);
         #1 seen = seen | {done, abrt, seq};
      end
      chk({13'h0, seen}, {13'h0, r});
      chk({15'h0, latch}, {15'h0, w});
      chk(prot, ep);
   endtask : cmd
   task automatic wen;
      cmd({8'h06, 32'h0}, 8, 1'b1, 3'h4);
   endtask : wen
   task automatic t_reset;
      chk(prot, 16'hFFFF);
      chk({15'h0, latch}, 16'h0);
      ep = 16'hFFFF;
      $display("test reset done");
   endtask : t_reset
   task automatic t_latch;
      wen();
      cmd({8'h04, 8'hA5, 24'h0}, 16, 1'b0, 3'h5);
      cmd({8'h06, 32'h0}, 7, 1'b0, 3'h0);
      wen();
      cmd({8'h04, 32'h0}, 12, 1'b1, 3'h2);
      cmd({8'h04, 32'h0}, 8, 1'b0, 3'h5);
      $display("test latch done");
   endtask : t_latch
   task automatic t_sector;
      cmd({8'h39, 24'h35ABCD, 8'h0}, 32, 1'b0, 3'h2);
      wen();
      ep[5] = 1'b0;
      cmd({8'h39, 24'h35ABCD, 8'h5A}, 40, 1'b0, 3'h4);
      wen();
      ep[2] = 1'b0;
      cmd({8'h39, 24'h020000, 8'h0}, 32, 1'b0, 3'h4);
      wen();
      @(posedge clk_in) addr <= 24'h35FFFF;
      repeat (2) @(posedge clk_in);
      #1 chk({15'h0, allowed}, 16'h1);
      @(posedge clk_in) addr <= 24'h360000;
      repeat (2) @(posedge clk_in);
      #1 chk({15'h0, allowed}, 16'h0);
      @(posedge clk_in) op_end <= 1'b1;
      @(posedge clk_in) op_end <= 1'b0;
      #1 chk({15'h0, latch}, 16'h0);
      wen();
      ep[5] = 1'b1;
      cmd({8'h36, 24'h350000, 8'h0}, 32, 1'b0, 3'h4);
      wen();
      cmd({8'h39, 24'h350000, 8'h0}, 24, 1'b0, 3'h2);
      wen();
      cmd({8'h39, 24'h350000, 8'h0}, 36, 1'b0, 3'h2);
      @(posedge clk_in) lock <= 1'b1;
      wen();
      cmd({8'h39, 24'h350000, 8'h0}, 32, 1'b0, 3'h2);
      wen();
      cmd({8'h36, 24'h020000, 8'h0}, 32, 1'b0, 3'h2);
      @(posedge clk_in) lock <= 1'b0;
      $display("test sector done");
   endtask : t_sector
   task automatic do_reset;
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1 t_reset();
   endtask : do_reset
   initial begin
      do_reset();
      t_latch();
      t_sector();
      do_reset();
      end_sim();
   end
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errors++;
         end_sim();
      end
   end
endmodule : testbench
